// [common/ccd_seq_pkg.sv]
// Constants for the CCD board initialiser and line/frame timing sequencer.
// Assumes a 100 MHz system clock; all pixel timing is derived from it.
// What this block does
// - Horizontal phase and reset clocks run with one 50 ns pixel period.
// - One pixel wait after horizontal clocks stop, before vertical transfer.
// - Vertical phase two stays high 40 pixel counts per line transfer.
// - Thirty pixel counts after vertical transfer before horizontal clocks resume.
// - Each line reads 1120 pixel counts, sixty of them overclock pixels.
// - Each frame reads 1056 lines, each a vertical period plus line pixels.
// - Photodiode transfer holds third level 360 counts, then 800 counts wait.
// - Shutter pulse: 30 counts setup, 150 counts wide, 20 counts hold.
// - Pixel sync clock to the frame grabber pulses once per 50 ns.
// - Integration select inputs pick full frame down to one eighth frame.
// - Any reset reloads front-end defaults first, then timing generator settings.
// - After initialisation, keep monitoring timing generator activity and serial port.
// - Black clamp asserted over dark pixels at fixed counts 4 to 14; serial writes do not move it.
// - Front-end defaults: 0 to addresses 0 and 1, 96 to 2, 20 to 3.
// - Frame table pointer defaults to 0, or 1 when binning is selected.
// - System clock runs at twice the pixel rate or faster.
// - Binning jumper high selects 2x2 binning, low selects no binning.
// - Timing generator load starts in program mode, ends in execution mode.
package ccd_seq_pkg;
  // Clock and pixel timing.
  localparam int CLK_NS   = 10;
  localparam int PIX_NS   = 50;
  localparam int PIX_CYC  = (PIX_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIX_HIGH = (PIX_CYC + 1) / 2;
  localparam int SCLK_HALF = 2;

  // Durations and clamp positions in pixel counts; frame and shutter lines in lines.
  localparam logic [10:0] V_DELAY_PIX  = 11'h001;
  localparam logic [10:0] V_XFER_PIX   = 11'h028;
  localparam logic [10:0] H_DELAY_PIX  = 11'h01e;
  localparam logic [10:0] LINE_PIX     = 11'h460;
  localparam logic [10:0] PD_XFER_PIX  = 11'h168;
  localparam logic [10:0] PD_DELAY_PIX = 11'h320;
  localparam logic [10:0] SH_SETUP_PIX = 11'h01e;
  localparam logic [10:0] SH_PULSE_PIX = 11'h096;
  localparam logic [10:0] SH_HOLD_PIX  = 11'h014;
  localparam logic [10:0] CLAMP_START  = 11'h004;
  localparam logic [10:0] CLAMP_END    = 11'h00e;
  localparam logic [12:0] FRAME_LINES  = 13'h0420;
  localparam logic [12:0] SHUT_OFF_LINE = 13'h044c;

  // Vertical phase two drive levels.
  localparam logic [1:0] VL_LOW   = 2'h0;
  localparam logic [1:0] VL_HIGH  = 2'h1;
  localparam logic [1:0] VL_THIRD = 2'h2;

  // Serial word layout: write bit, four address bits, then data, LSB first.
  localparam int WORD_W  = 40;
  localparam int NBITS_W = 6;
  localparam int HDR_BITS = 5;
  localparam int AFE_DATA_W = 8;
  localparam int INIT_STEPS = 9;

  // Front-end default values and addresses.
  localparam logic [3:0] AFE_A_OP    = 4'h0;
  localparam logic [3:0] AFE_A_CTRL  = 4'h1;
  localparam logic [3:0] AFE_A_CLAMP = 4'h2;
  localparam logic [3:0] AFE_A_GAIN  = 4'h3;
  localparam logic [7:0] AFE_OP      = 8'h00;
  localparam logic [7:0] AFE_CTRL    = 8'h00;
  localparam logic [7:0] AFE_CLAMP   = 8'h60;
  localparam logic [7:0] AFE_GAIN    = 8'h14;

  // Timing generator registers.
  localparam logic [3:0] TG_A_PTR   = 4'h0;
  localparam logic [3:0] TG_A_CTRL  = 4'h2;
  localparam logic [3:0] TG_A_SHUT  = 4'h3;
  localparam logic [3:0] TG_A_SLINE = 4'h4;
  localparam logic [1:0] TG_CTRL_PROG = 2'h0;
  localparam logic [1:0] TG_CTRL_EXEC = 2'h2;
  localparam logic [3:0] PTR_SINGLE = 4'h0;
  localparam logic [3:0] PTR_BIN    = 4'h1;

  // Device select codes and load-line masks {tg, afe2, afe1}.
  localparam logic [2:0] DS_AFE1 = 3'h1;
  localparam logic [2:0] DS_AFE2 = 3'h2;
  localparam logic [2:0] DS_TG   = 3'h3;
  localparam logic [2:0] LD_NONE = 3'h0;
  localparam logic [2:0] LD_AFE1 = 3'h1;
  localparam logic [2:0] LD_AFE2 = 3'h2;
  localparam logic [2:0] LD_AFES = 3'h3;
  localparam logic [2:0] LD_TG   = 3'h4;
endpackage : ccd_seq_pkg

// [common/ser_if.sv]
// Request path between the sequencer and its serial shifter.
// Assumes both ends run on the same system clock.
interface ser_if;
  logic                               start;
  logic [ccd_seq_pkg::WORD_W-1:0]     word;
  logic [ccd_seq_pkg::NBITS_W-1:0]    nbits;
  logic                               busy;

  modport master  (output start, output word, output nbits, input busy);
  modport shifter (input start, input word, input nbits, output busy);
endinterface : ser_if

// [rtl/serial_shifter.sv]
// Three-wire serial writer: shifts one word out LSB first.
// Assumes start is only raised while busy is low.
module serial_shifter #(
  parameter int SCLK_HALF = ccd_seq_pkg::SCLK_HALF
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  ser_if.shifter    req,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      load_n_o
);
  logic [ccd_seq_pkg::WORD_W-1:0]  sh_ff;
  logic [ccd_seq_pkg::NBITS_W-1:0] left_ff;
  logic [3:0]                      half_ff;
  logic                            sclk_ff;
  logic                            busy_ff;
  logic                            half_end;

  if (SCLK_HALF < 1 || SCLK_HALF > 15) begin : g_chk
    $error("SCLK_HALF out of range");
  end

  // Half-period end of the serial clock.
  assign half_end = (half_ff == 4'(SCLK_HALF - 1));

  // Data changes on the falling edge, devices sample on the rising edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_ff   <= '0;
      left_ff <= '0;
      half_ff <= 4'h0;
      sclk_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (!busy_ff) begin
      if (req.start) begin
        sh_ff   <= req.word;
        left_ff <= req.nbits;
        half_ff <= 4'h0;
        sclk_ff <= 1'b0;
        busy_ff <= (req.nbits != '0);
      end
    end else if (half_end) begin
      half_ff <= 4'h0;
      sclk_ff <= ~sclk_ff;
      if (sclk_ff) begin
        sh_ff   <= sh_ff >> 1;
        left_ff <= left_ff - 1'b1;
        busy_ff <= (left_ff != 6'h01);
      end
    end else begin
      half_ff <= half_ff + 4'h1;
    end
  end

  assign req.busy = busy_ff;
  assign sclk_o   = sclk_ff;
  assign sdata_o  = sh_ff[0];
  assign load_n_o = ~busy_ff;
endmodule : serial_shifter

// [rtl/ccd_board_sequencer.sv]
// Board controller: default serial load of front ends and timing generator,
// serial steering of external writes, and fixed CCD line/frame timing.
// Assumes all inputs other than the reset are asynchronous to clk_i.
module ccd_board_sequencer #(
  parameter int PIX_CYC = ccd_seq_pkg::PIX_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       remote_reset_i,
  input  wire logic [4:0] integration_select_i,
  input  wire logic       binning_jumper_i,
  input  wire logic       ext_sload_n_i,
  input  wire logic       ext_sclk_i,
  input  wire logic       ext_sdata_i,
  input  wire logic       tg_line_valid_i,
  input  wire logic       tg_frame_valid_i,
  output logic            horiz_phase_one_o,
  output logic            horiz_last_gate_o,
  output logic            horiz_phase_two_o,
  output logic            ccd_reset_clk_o,
  output logic [1:0]      vert_phase_two_o,
  output logic            shutter_pulse_o,
  output logic            optical_black_clamp_o,
  output logic            pixel_sync_clock_o,
  output logic            line_valid_mon_o,
  output logic            frame_valid_mon_o,
  output logic            sload_afe1_n_o,
  output logic            sload_afe2_n_o,
  output logic            sload_tg_n_o,
  output logic            sclk_o,
  output logic            sdata_o,
  output logic            init_done_o
);
  typedef enum logic [3:0] {
    I_WAIT = 4'h1, I_ISSUE = 4'h2, I_BUSY = 4'h4, I_RUN = 4'h8
  } init_st_t;
  typedef enum logic [9:0] {
    T_IDLE = 10'h001, T_PD_XFER = 10'h002, T_PD_DELAY = 10'h004,
    T_SH_SETUP = 10'h008, T_SH_PULSE = 10'h010, T_SH_HOLD = 10'h020,
    T_V_DELAY = 10'h040, T_V_XFER = 10'h080, T_H_DELAY = 10'h100, T_H_READ = 10'h200
  } tim_st_t;

  if (PIX_CYC < 2 || PIX_CYC > 15) begin : g_chk
    $error("PIX_CYC must lie between 2 and 15");
  end

  // Length in pixel counts of each timing phase.
  function automatic logic [10:0] phase_len(input tim_st_t s);
    unique case (s)
      T_PD_XFER:  phase_len = ccd_seq_pkg::PD_XFER_PIX;
      T_PD_DELAY: phase_len = ccd_seq_pkg::PD_DELAY_PIX;
      T_SH_SETUP: phase_len = ccd_seq_pkg::SH_SETUP_PIX;
      T_SH_PULSE: phase_len = ccd_seq_pkg::SH_PULSE_PIX;
      T_SH_HOLD:  phase_len = ccd_seq_pkg::SH_HOLD_PIX;
      T_V_DELAY:  phase_len = ccd_seq_pkg::V_DELAY_PIX;
      T_V_XFER:   phase_len = ccd_seq_pkg::V_XFER_PIX;
      T_H_DELAY:  phase_len = ccd_seq_pkg::H_DELAY_PIX;
      T_H_READ:   phase_len = ccd_seq_pkg::LINE_PIX;
      default:    phase_len = 11'h001;
    endcase
  endfunction : phase_len

  // Load-line mask for a device select code.
  function automatic logic [2:0] ds_mask(input logic [2:0] ds);
    unique case (ds)
      ccd_seq_pkg::DS_AFE1: ds_mask = ccd_seq_pkg::LD_AFE1;
      ccd_seq_pkg::DS_AFE2: ds_mask = ccd_seq_pkg::LD_AFE2;
      ccd_seq_pkg::DS_TG:   ds_mask = ccd_seq_pkg::LD_TG;
      default:              ds_mask = ccd_seq_pkg::LD_NONE;
    endcase
  endfunction : ds_mask

  // Serial word for one init step: {write bit, address, data}, LSB first.
  function automatic logic [ccd_seq_pkg::WORD_W-1:0] mk_word(input logic [3:0] a,
                                                             input logic [29:0] d);
    mk_word = {5'h00, d, a, 1'b0};
  endfunction : mk_word

  init_st_t    i_ff, nxt_i;
  tim_st_t     t_ff, nxt_t;
  logic [3:0]  step_ff, nxt_step;
  logic        pend_ff;
  logic [4:0]  isel_ff;
  logic        bin_ff;
  logic [3:0]  pdiv_ff;
  logic [10:0] cnt_ff, nxt_cnt;
  logic [12:0] line_ff, nxt_line;
  logic [2:0]  rr_ff, sl_ff, sc_ff;
  logic [9:0]  is_ff;
  logic [1:0]  sd_ff, lv_ff, fv_ff, bj_ff;
  logic [2:0]  eds_ff, emask_ff;
  logic [1:0]  ebits_ff;

  // Synchroniser chains; stage 0 is read only by stage 1.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rr_ff <= 3'h0;
      sl_ff <= 3'h7;
      sc_ff <= 3'h0;
      sd_ff <= 2'h0;
      lv_ff <= 2'h0;
      fv_ff <= 2'h0;
      is_ff <= 10'h000;
      bj_ff <= 2'h0;
    end else begin
      is_ff <= {is_ff[4:0], integration_select_i};
      bj_ff <= {bj_ff[0], binning_jumper_i};
      rr_ff <= {rr_ff[1:0], remote_reset_i};
      sl_ff <= {sl_ff[1:0], ext_sload_n_i};
      sc_ff <= {sc_ff[1:0], ext_sclk_i};
      sd_ff <= {sd_ff[0], ext_sdata_i};
      lv_ff <= {lv_ff[0], tg_line_valid_i};
      fv_ff <= {fv_ff[0], tg_frame_valid_i};
    end
  end

  logic rr_high, rr_fall, run, sl_fall, sl_rise, sc_rise, sc_fall;
  assign rr_high = rr_ff[1];
  assign rr_fall = rr_ff[2] & ~rr_ff[1];
  assign sl_fall = sl_ff[2] & ~sl_ff[1];
  assign sl_rise = ~sl_ff[2] & sl_ff[1];
  assign sc_rise = ~sc_ff[2] & sc_ff[1];
  assign sc_fall = sc_ff[2] & ~sc_ff[1];
  assign run     = (i_ff == I_RUN);

  // Init step table and shifter requests.
  logic [12:0] shut_line;
  logic [16:0] shut_prod;
  logic [3:0]  ptr_val;
  logic [2:0]  cur_mask;
  logic [ccd_seq_pkg::WORD_W-1:0] cur_word;
  logic [ccd_seq_pkg::NBITS_W-1:0] cur_nbits;
  logic        sh_sclk, sh_sdata, sh_load_n;
  ser_if       ser ();

  assign shut_prod = 17'(ccd_seq_pkg::FRAME_LINES) * 17'(4'h8 - {1'b0, isel_ff[2:0]});
  assign shut_line = (isel_ff == 5'h00 || isel_ff > 5'h07) ? ccd_seq_pkg::SHUT_OFF_LINE :
                     bin_ff ? 13'(shut_prod[16:4]) : shut_prod[15:3];
  assign ptr_val = bin_ff ? ccd_seq_pkg::PTR_BIN : ccd_seq_pkg::PTR_SINGLE;

  // Front-end defaults to both front ends, then program mode first.
  always_comb begin
    cur_mask  = ccd_seq_pkg::LD_TG;
    cur_nbits = 6'(ccd_seq_pkg::HDR_BITS + 30);
    unique case (step_ff)
      4'h0: cur_word = mk_word(ccd_seq_pkg::AFE_A_OP, 30'(ccd_seq_pkg::AFE_OP));
      4'h1: cur_word = mk_word(ccd_seq_pkg::AFE_A_CTRL, 30'(ccd_seq_pkg::AFE_CTRL));
      4'h2: cur_word = mk_word(ccd_seq_pkg::AFE_A_CLAMP, 30'(ccd_seq_pkg::AFE_CLAMP));
      4'h3: cur_word = mk_word(ccd_seq_pkg::AFE_A_GAIN, 30'(ccd_seq_pkg::AFE_GAIN));
      4'h4: cur_word = mk_word(ccd_seq_pkg::TG_A_CTRL, 30'(ccd_seq_pkg::TG_CTRL_PROG));
      4'h5: cur_word = mk_word(ccd_seq_pkg::TG_A_PTR, 30'(ptr_val));
      4'h6: cur_word = mk_word(ccd_seq_pkg::TG_A_SHUT,
                               {ccd_seq_pkg::SH_HOLD_PIX[9:0], ccd_seq_pkg::SH_PULSE_PIX[9:0],
                                ccd_seq_pkg::SH_SETUP_PIX[9:0]});
      4'h7: cur_word = mk_word(ccd_seq_pkg::TG_A_SLINE, 30'(shut_line));
      default: cur_word = mk_word(ccd_seq_pkg::TG_A_CTRL, 30'(ccd_seq_pkg::TG_CTRL_EXEC));
    endcase
    if (step_ff < 4'h4) begin
      cur_mask  = ccd_seq_pkg::LD_AFES;
      cur_nbits = 6'(ccd_seq_pkg::HDR_BITS + ccd_seq_pkg::AFE_DATA_W);
    end
  end

  assign ser.start = (i_ff == I_ISSUE);
  assign ser.word  = cur_word;
  assign ser.nbits = cur_nbits;

  serial_shifter u_shift (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .req      (ser.shifter),
    .sclk_o   (sh_sclk),
    .sdata_o  (sh_sdata),
    .load_n_o (sh_load_n)
  );

  // Init sequencer; a held remote reset parks it, its release restarts it.
  always_comb begin
    nxt_i    = i_ff;
    nxt_step = step_ff;
    unique case (i_ff)
      I_WAIT:  if (pend_ff) begin
                 nxt_i    = I_ISSUE;
                 nxt_step = 4'h0;
               end
      I_ISSUE: nxt_i = I_BUSY;
      I_BUSY:  if (!ser.busy) begin
                 nxt_i    = (step_ff == 4'(ccd_seq_pkg::INIT_STEPS - 1)) ? I_RUN : I_ISSUE;
                 nxt_step = step_ff + 4'h1;
               end
      I_RUN:   nxt_i = I_RUN;
      default: nxt_i = I_WAIT;
    endcase
    if (rr_high) begin
      nxt_i = I_WAIT;
    end
  end

  // Init state, pending start, and straps tracked until the load completes.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      i_ff    <= I_WAIT;
      step_ff <= 4'h0;
      pend_ff <= 1'b1;
      isel_ff <= 5'h00;
      bin_ff  <= 1'b0;
    end else begin
      i_ff    <= nxt_i;
      step_ff <= nxt_step;
      pend_ff <= rr_fall | (pend_ff & ~(i_ff == I_WAIT && nxt_i == I_ISSUE));
      if (!run) begin
        isel_ff <= is_ff[9:5];
        bin_ff  <= bj_ff[1];
      end
    end
  end

  // External write decode: only while running, device select stripped.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eds_ff   <= 3'h0;
      emask_ff <= 3'h0;
      ebits_ff <= 2'h0;
    end else if (!run || sl_rise || sl_fall) begin
      eds_ff   <= 3'h0;
      emask_ff <= 3'h0;
      ebits_ff <= 2'h0;
    end else if (sc_rise && !sl_ff[1] && ebits_ff != 2'h3) begin
      eds_ff   <= {eds_ff[1:0], sd_ff[1]};
      ebits_ff <= ebits_ff + 2'h1;
    end else if (sc_fall && ebits_ff == 2'h3) begin
      // Open the load with the clock low, so no false rise.
      emask_ff <= ds_mask(eds_ff);
    end
  end

  // Serial pin selection between forwarded and default traffic.
  logic       ext_act;
  logic [2:0] ld_mask;
  assign ext_act = (emask_ff != 3'h0);
  assign ld_mask = ext_act ? emask_ff : (sh_load_n ? 3'h0 : cur_mask);

  // Pixel divider; one tick per pixel.
  logic pix_tick, last;
  assign pix_tick = (pdiv_ff == 4'(PIX_CYC - 1));
  assign last     = pix_tick && (cnt_ff == phase_len(t_ff) - 11'h001);

  always_comb begin
    nxt_t    = t_ff;
    nxt_line = line_ff;
    unique case (t_ff)
      T_IDLE:     if (pix_tick) nxt_t = T_PD_XFER;
      T_PD_XFER:  if (last) nxt_t = T_PD_DELAY;
      T_PD_DELAY: if (last) begin
                    nxt_line = 13'h0000;
                    nxt_t    = (shut_line == 13'h0000) ? T_SH_SETUP : T_V_DELAY;
                  end
      T_SH_SETUP: if (last) nxt_t = T_SH_PULSE;
      T_SH_PULSE: if (last) nxt_t = T_SH_HOLD;
      T_SH_HOLD:  if (last) nxt_t = T_V_DELAY;
      T_V_DELAY:  if (last) nxt_t = T_V_XFER;
      T_V_XFER:   if (last) nxt_t = T_H_DELAY;
      T_H_DELAY:  if (last) nxt_t = T_H_READ;
      T_H_READ:   if (last) begin
                    nxt_line = line_ff + 13'h0001;
                    if (line_ff == ccd_seq_pkg::FRAME_LINES - 13'h0001) begin
                      nxt_t = T_PD_XFER;
                    end else begin
                      nxt_t = (nxt_line == shut_line) ? T_SH_SETUP : T_V_DELAY;
                    end
                  end
      default:    nxt_t = T_IDLE;
    endcase
    if (!run) begin
      nxt_t = T_IDLE;
    end
    nxt_cnt = (nxt_t != t_ff) ? 11'h000 : (pix_tick ? cnt_ff + 11'h001 : cnt_ff);
  end

  // Timing state, pixel divider and counters.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_ff    <= T_IDLE;
      pdiv_ff <= 4'h0;
      cnt_ff  <= 11'h000;
      line_ff <= 13'h0000;
    end else begin
      t_ff    <= nxt_t;
      pdiv_ff <= pix_tick ? 4'h0 : pdiv_ff + 4'h1;
      cnt_ff  <= nxt_cnt;
      line_ff <= nxt_line;
    end
  end

  // Output decode.
  logic in_read, pix_hi, clamp_win;
  assign in_read   = (t_ff == T_H_READ);
  assign pix_hi    = (pdiv_ff < 4'(ccd_seq_pkg::PIX_HIGH));
  assign clamp_win = in_read && cnt_ff >= ccd_seq_pkg::CLAMP_START &&
                     cnt_ff <= ccd_seq_pkg::CLAMP_END;

  // Registered pins; horizontal clocks idle with phase one high.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      horiz_phase_one_o     <= 1'b1;
      horiz_last_gate_o     <= 1'b1;
      horiz_phase_two_o     <= 1'b0;
      ccd_reset_clk_o       <= 1'b0;
      vert_phase_two_o      <= ccd_seq_pkg::VL_LOW;
      shutter_pulse_o       <= 1'b0;
      optical_black_clamp_o <= 1'b0;
      pixel_sync_clock_o    <= 1'b0;
      line_valid_mon_o      <= 1'b0;
      frame_valid_mon_o     <= 1'b0;
      sload_afe1_n_o        <= 1'b1;
      sload_afe2_n_o        <= 1'b1;
      sload_tg_n_o          <= 1'b1;
      sclk_o                <= 1'b0;
      sdata_o               <= 1'b0;
      init_done_o           <= 1'b0;
    end else begin
      horiz_phase_one_o     <= ~in_read | pix_hi;
      horiz_last_gate_o     <= ~in_read | pix_hi;
      horiz_phase_two_o     <= in_read & ~pix_hi;
      ccd_reset_clk_o       <= in_read && pdiv_ff == 4'h0;
      vert_phase_two_o      <= (t_ff == T_V_XFER) ? ccd_seq_pkg::VL_HIGH :
                               (t_ff == T_PD_XFER) ? ccd_seq_pkg::VL_THIRD : ccd_seq_pkg::VL_LOW;
      shutter_pulse_o       <= (t_ff == T_SH_PULSE);
      optical_black_clamp_o <= clamp_win;
      pixel_sync_clock_o    <= pix_hi;
      line_valid_mon_o      <= lv_ff[1] & run;
      frame_valid_mon_o     <= fv_ff[1] & run;
      sload_afe1_n_o        <= ~ld_mask[0];
      sload_afe2_n_o        <= ~ld_mask[1];
      sload_tg_n_o          <= ~ld_mask[2];
      sclk_o                <= ext_act ? sc_ff[1] : sh_sclk;
      sdata_o               <= ext_act ? sd_ff[1] : sh_sdata;
      init_done_o           <= run;
    end
  end
endmodule : ccd_board_sequencer

// [bench/ccd_board_sequencer_chk.sv]
// Checker for the board sequencer: pixel, vertical and shutter timing at the ports.
// Assumes it is bound to the top module, with PIX_CYC clocks per pixel.
module ccd_board_sequencer_chk #(
  parameter int PIX_CYC = 5
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       remote_reset_i,
  input wire logic       horiz_phase_one_o,
  input wire logic       horiz_phase_two_o,
  input wire logic       ccd_reset_clk_o,
  input wire logic [1:0] vert_phase_two_o,
  input wire logic       shutter_pulse_o,
  input wire logic       pixel_sync_clock_o,
  input wire logic       line_valid_mon_o,
  input wire logic       init_done_o
);
  logic [11:0] vh_ff;
  logic [11:0] pd_ff;
  logic [11:0] sh_ff;
  logic        vh;
  logic        pd;
  // Decode the vertical drive levels.
  assign vh = vert_phase_two_o == ccd_seq_pkg::VL_HIGH;
  assign pd = vert_phase_two_o == ccd_seq_pkg::VL_THIRD;
  // Run lengths of the vertical high, third level and shutter phases.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vh_ff <= 12'h000;
      pd_ff <= 12'h000;
      sh_ff <= 12'h000;
    end else begin
      vh_ff <= vh ? vh_ff + 12'h001 : 12'h000;
      pd_ff <= pd ? pd_ff + 12'h001 : 12'h000;
      sh_ff <= shutter_pulse_o ? sh_ff + 12'h001 : 12'h000;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || remote_reset_i);
  sequence sync_high_s;
    pixel_sync_clock_o [*3];
  endsequence
  sequence sync_low_s;
    !pixel_sync_clock_o [*2];
  endsequence
  chk_pixel_period: assert property ($rose(ccd_reset_clk_o) |=> !ccd_reset_clk_o [*4])
    else $error("reset clock pulses closer than one pixel");
  chk_hclk_stopped: assert property (vert_phase_two_o != 2'h0 |-> horiz_phase_one_o && !horiz_phase_two_o)
    else $error("horizontal clocks run during a vertical phase");
  chk_vert_width: assert property ($fell(vh) |-> vh_ff == 40 * PIX_CYC)
    else $error("vertical high phase has the wrong length");
  chk_hres_gap: assert property ($fell(vh) |-> !ccd_reset_clk_o [*8])
    else $error("horizontal clocks resume too soon");
  chk_third_level: assert property ($fell(pd) |-> pd_ff == 360 * PIX_CYC)
    else $error("third level phase has the wrong length");
  chk_shutter_width: assert property ($fell(shutter_pulse_o) |-> sh_ff == 150 * PIX_CYC)
    else $error("shutter pulse has the wrong width");
  chk_sync_clock: assert property ($rose(pixel_sync_clock_o) |-> sync_high_s ##1 sync_low_s ##1 pixel_sync_clock_o)
    else $error("pixel sync clock period is wrong");
  chk_mon_gated: assert property (!init_done_o && !$past(init_done_o) |-> !line_valid_mon_o)
    else $error("line monitor active before initialisation");
endmodule : ccd_board_sequencer_chk
bind ccd_board_sequencer ccd_board_sequencer_chk #(.PIX_CYC(PIX_CYC)) chk_i (.clk_i, .rst_n_i,
  .remote_reset_i, .horiz_phase_one_o, .horiz_phase_two_o, .ccd_reset_clk_o, .vert_phase_two_o,
  .shutter_pulse_o, .pixel_sync_clock_o, .line_valid_mon_o, .init_done_o);

// [bench/ccd_far_side.sv]
// Far-side model: front ends and timing generator receiving serial words.
// Assumes devices sample data on the rising serial clock while their load is low.
module ccd_far_side (
  input  wire logic sclk_i,
  input  wire logic sdata_i,
  input  wire logic sload_afe1_n_i,
  input  wire logic sload_afe2_n_i,
  input  wire logic sload_tg_n_i,
  output logic      tg_line_valid_o,
  output logic      tg_frame_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] sh = 40'h0;
  logic [5:0]  n = 6'h00;
  logic [2:0]  m = 3'h0;
  logic [2:0]  rec_dev [$];
  logic [5:0]  rec_len [$];
  logic [39:0] rec_word [$];
  wire  [2:0]  lds = ~{sload_tg_n_i, sload_afe2_n_i, sload_afe1_n_i};
  // The timing generator reports an active line and an idle frame.
  assign tg_line_valid_o = 1'b1;
  assign tg_frame_valid_o = 1'b0;
  // Shift in one bit, LSB first, on each rising clock while a load is low.
  always @(posedge sclk_i) begin
    if (lds != 3'h0) begin
      sh = {sdata_i, sh[39:1]};
      n = n + 6'h01;
      m = m | lds;
    end
  end
  // Store the word once every load is high again.
  always @(lds) begin
    if (lds == 3'h0 && n != 6'h00) begin
      rec_dev.push_back(m);
      rec_len.push_back(n);
      rec_word.push_back(sh >> (40 - n));
      n = 6'h00;
      m = 3'h0;
      sh = 40'h0;
    end
  end
endmodule : ccd_far_side

// [bench/ccd_board_sequencer_test.sv]
// Testbench for the board sequencer: default load, external writes, line timing.
// Assumes the far-side model records each serial word the design sends.
module ccd_board_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rr = 1'b0;
  logic [4:0] isel = 5'h01;
  logic bj = 1'b0;
  logic esl_n = 1'b1;
  logic esc = 1'b0;
  logic esd = 1'b0;
  logic lv, fv, h1, hl, h2, rc, sp, cl, ps, lm, fm, l1, l2, lt, sc, sd, dn;
  logic [1:0] vp;
  logic [7:0] dv [4] = '{8'h00, 8'h00, 8'h60, 8'h14};
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int base;
  int c;
  ccd_board_sequencer dut (.clk_i, .rst_n_i, .remote_reset_i(rr), .integration_select_i(isel),
    .binning_jumper_i(bj), .ext_sload_n_i(esl_n), .ext_sclk_i(esc), .ext_sdata_i(esd),
    .tg_line_valid_i(lv), .tg_frame_valid_i(fv), .horiz_phase_one_o(h1), .horiz_last_gate_o(hl),
    .horiz_phase_two_o(h2), .ccd_reset_clk_o(rc), .vert_phase_two_o(vp), .shutter_pulse_o(sp),
    .optical_black_clamp_o(cl), .pixel_sync_clock_o(ps), .line_valid_mon_o(lm),
    .frame_valid_mon_o(fm), .sload_afe1_n_o(l1), .sload_afe2_n_o(l2), .sload_tg_n_o(lt),
    .sclk_o(sc), .sdata_o(sd), .init_done_o(dn));
  ccd_far_side far (.sclk_i(sc), .sdata_i(sd), .sload_afe1_n_i(l1), .sload_afe2_n_i(l2),
    .sload_tg_n_i(lt), .tg_line_valid_o(lv), .tg_frame_valid_o(fv));
  // Clock and a cycle ceiling that cuts a hang short.
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rec(input int i, input logic [2:0] d, input logic [5:0] n, input logic [39:0] w);
    check("device", far.rec_dev[i], 40'(d));
    check("length", far.rec_len[i], 40'(n));
    check("word", far.rec_word[i], w);
  endtask : rec
  task automatic wait_done();
    int k = 0;
    while (dn !== 1'b1 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_done
  // Sends three select bits MSB first, then n bits LSB first, at 160 ns per bit.
  task automatic ext_write(input logic [2:0] ds, input int n, input logic [39:0] w);
    logic [42:0] b;
    b = {w, ds[0], ds[1], ds[2]};
    @(posedge clk_i) esl_n <= 1'b0;
    for (int i = 0; i < n + 3; i++) begin
      repeat (8) @(posedge clk_i);
      esc <= 1'b0;
      esd <= b[i];
      repeat (8) @(posedge clk_i);
      esc <= 1'b1;
    end
    repeat (8) @(posedge clk_i);
    esc <= 1'b0;
    repeat (8) @(posedge clk_i);
    esl_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : ext_write
  task automatic init_words(input int s, input logic [3:0] ptr, input logic [12:0] line);
    for (int i = 0; i < 4; i++) rec(s + i, 3'h3, 6'h0d, {27'h0, dv[i], 4'(i), 1'h0});
    rec(s + 4, 3'h4, 6'h23, 40'h0 | {4'h2, 1'h0});
    rec(s + 5, 3'h4, 6'h23, 40'h0 | {ptr, 4'h0, 1'h0});
    rec(s + 6, 3'h4, 6'h23, {5'h0, 10'h014, 10'h096, 10'h01e, 4'h3, 1'h0});
    rec(s + 7, 3'h4, 6'h23, 40'h0 | {line, 4'h4, 1'h0});
    rec(s + 8, 3'h4, 6'h23, 40'h0 | {2'h2, 4'h2, 1'h0});
  endtask : init_words
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // Main sequence of tests.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    check("monitor early", 40'(lm), 40'h0);
    wait_done();
    repeat (6) @(posedge clk_i);
    init_words(0, 4'h0, 13'h39c);
    check("line monitor", 40'({lm, fm}), 40'h2);
    $display("test default load done");
    ext_write(3'h2, 13, 40'h0b42);
    rec(9, 3'h2, 6'h0d, 40'h0b42);
    ext_write(3'h4, 13, 40'h0b42);
    check("dropped write", 40'(far.rec_dev.size()), 40'h0a);
    $display("test external writes done");
    c = 0;
    base = 0;
    while (vp !== 2'h1 && cyc < 30000) @(posedge clk_i);
    while (vp === 2'h1 && cyc < 30000) @(posedge clk_i);
    while (vp !== 2'h1 && cyc < 30000) begin
      @(posedge clk_i);
      c += rc;
      base += cl + (hl ^ h1);
    end
    check("line pixels", 40'(c), 40'h460);
    check("clamp cycles", 40'(base), 40'h37);
    $display("test line read done");
    rr <= 1'b1;
    bj <= 1'b1;
    isel <= 5'h02;
    repeat (10) @(posedge clk_i);
    check("done in reset", 40'(dn), 40'h0);
    ext_write(3'h3, 35, 40'h0);
    check("refused write", 40'(far.rec_dev.size()), 40'h0a);
    // Operator releases the remote reset so the new selects take effect.
    rr <= 1'b0;
    repeat (4) @(posedge clk_i);
    wait_done();
    repeat (6) @(posedge clk_i);
    init_words(10, 4'h1, 13'h18c);
    $display("test remote reset done");
    wrap_up();
  end
endmodule : ccd_board_sequencer_test
